// file: src/io_port_pkg.sv
// Operation
// - Two bidirectional pins, indexed 1 and 0, each with direction and data bit
// - Direction one drives pin from data bit; zero makes it input, driver off
// - Direction register is write-only; every read returns all ones
// - Bits 7 to 2 of both registers read as one and ignore writes
// - Direction register resets to FC, both pins inputs
// - Data register resets to FC, both data bits zero
// - Data register holds output values, software writes and reads both bits
// - Output pins read back the stored data bit, not the pin level
// - Input pins read back the sampled pin level
// - Reset high impedance; sleep holds; standby, watch, subactive float; active normal
package io_port_pkg;
    localparam int          PIN_COUNT      = 2;
    localparam int          REG_WIDTH      = 8;
    localparam logic [15:0] DATA_OFFSET    = 16'hFFDA;
    localparam logic [15:0] DIR_OFFSET     = 16'hFFEA;
    localparam logic [15:0] MODE_OFFSET    = 16'hFFF0;
    localparam logic [7:0]  DATA_RESET     = 8'hFC;
    localparam logic [7:0]  DIR_RESET      = 8'hFC;
    localparam logic [7:0]  RESERVED_ONES  = 8'hFC;
    localparam logic [7:0]  ALL_ONES       = 8'hFF;

    typedef enum logic [2:0] {
        MODE_ACTIVE    = 3'h0,
        MODE_SLEEP     = 3'h1,
        MODE_STANDBY   = 3'h3,
        MODE_WATCH     = 3'h2,
        MODE_SUBACTIVE = 3'h6
    } power_mode_t;
endpackage

// file: src/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_q;

    // Two-stage synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_q  <= '0;
            sync_out <= '0;
        end else begin
            stage_q  <= async_in;
            sync_out <= stage_q;
        end
    end
endmodule

// file: src/two_bit_io_port.sv
`timescale 1ns/10ps
module two_bit_io_port #(
    parameter int PINS = io_port_pkg::PIN_COUNT
) (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [15:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic [PINS-1:0] port_pin_in,
    output logic      [PINS-1:0] port_pin_out,
    output logic      [PINS-1:0] port_pin_oe_n
);
    logic [PINS-1:0]   dir_q;
    logic [PINS-1:0]   data_q;
    logic [2:0]        mode_q;
    logic [PINS-1:0]   pin_sync;
    logic [PINS-1:0]   held_out_q;
    logic [PINS-1:0]   held_oe_n_q;
    logic              access;
    logic              wr_en;
    logic              hit_data;
    logic              hit_dir;
    logic              hit_mode;
    logic [7:0]        data_view;
    logic [31:0]       rdata_d;

    function automatic logic [7:0] with_reserved(input logic [PINS-1:0] v);
        with_reserved = io_port_pkg::RESERVED_ONES | {{(8-PINS){1'b0}}, v};
    endfunction

    assign access   = psel && penable;
    assign wr_en    = access && pwrite;
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;

    always_comb begin
        hit_data = 1'b0;
        hit_dir  = 1'b0;
        hit_mode = 1'b0;
        if (paddr == io_port_pkg::DATA_OFFSET) begin
            hit_data = 1'b1;
        end else if (paddr == io_port_pkg::DIR_OFFSET) begin
            hit_dir = 1'b1;
        end else if (paddr == io_port_pkg::MODE_OFFSET) begin
            hit_mode = 1'b1;
        end
    end

    pin_sync #(
        .WIDTH (PINS)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (port_pin_in),
        .sync_out (pin_sync)
    );

    // Direction register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_q <= io_port_pkg::DIR_RESET[PINS-1:0];
        end else if (wr_en && hit_dir) begin
            dir_q <= pwdata[PINS-1:0];
        end
    end

    // Data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q <= io_port_pkg::DATA_RESET[PINS-1:0];
        end else if (wr_en && hit_data) begin
            data_q <= pwdata[PINS-1:0];
        end
    end

    // Power mode register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= io_port_pkg::MODE_ACTIVE;
        end else if (wr_en && hit_mode) begin
            mode_q <= pwdata[2:0];
        end
    end

    // Per-pin readback selects latched data or pin level
    always_comb begin
        data_view = with_reserved((dir_q & data_q) | (~dir_q & pin_sync));
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit_data) begin
            rdata_d = {24'h00_0000, data_view};
        end else if (hit_dir) begin
            rdata_d = {24'h00_0000, io_port_pkg::ALL_ONES};
        end else if (hit_mode) begin
            rdata_d = {29'h0000_0000, mode_q};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_d;
        end
    end

    // Pin drive per mode; sleep holds what was driven
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_out_q  <= '0;
            held_oe_n_q <= '1;
        end else begin
            case (mode_q)
                io_port_pkg::MODE_ACTIVE: begin
                    held_out_q  <= data_q;
                    held_oe_n_q <= ~dir_q;
                end
                io_port_pkg::MODE_SLEEP: begin
                    held_out_q  <= held_out_q;
                    held_oe_n_q <= held_oe_n_q;
                end
                default: begin
                    held_out_q  <= '0;
                    held_oe_n_q <= '1;
                end
            endcase
        end
    end

    assign port_pin_out  = held_out_q;
    assign port_pin_oe_n = held_oe_n_q;

    property p_dir_reads_ones;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_dir) |=> (prdata == 32'h0000_00FF);
    endproperty
    a_dir_reads_ones: assert property (p_dir_reads_ones) else $error("dir read not ones");

    property p_reserved_ones;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_data) |=> (prdata[7:2] == 6'h3F);
    endproperty
    a_reserved_ones: assert property (p_reserved_ones) else $error("reserved not one");

    property p_out_reads_data;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_data && dir_q[0])
            |=> (prdata[0] == $past(data_q[0]));
    endproperty
    a_out_reads_data: assert property (p_out_reads_data) else $error("out read wrong");

    property p_in_reads_pin;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_data && !dir_q[1])
            |=> (prdata[1] == $past(pin_sync[1]));
    endproperty
    a_in_reads_pin: assert property (p_in_reads_pin) else $error("in read wrong");

    property p_dir_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_dir) |=> (dir_q == $past(pwdata[PINS-1:0]));
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("dir write lost");

    property p_data_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_data) |=> (data_q == $past(pwdata[PINS-1:0]));
    endproperty
    a_data_write: assert property (p_data_write) else $error("data write lost");

    property p_active_drive;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == io_port_pkg::MODE_ACTIVE && $stable(mode_q))
            |=> (port_pin_oe_n == ~$past(dir_q) && port_pin_out == $past(data_q));
    endproperty
    a_active_drive: assert property (p_active_drive) else $error("active drive wrong");

    property p_standby_float;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == io_port_pkg::MODE_STANDBY) |=> (port_pin_oe_n == '1);
    endproperty
    a_standby_float: assert property (p_standby_float) else $error("standby drives");

    property p_sleep_hold;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == io_port_pkg::MODE_SLEEP && $past(mode_q) == io_port_pkg::MODE_SLEEP)
            |=> $stable(port_pin_oe_n);
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep not held");

    property p_sync_delay;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |-> ##2 (pin_sync == $past(port_pin_in, 2));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");
endmodule

// file: bench/two_bit_io_port_tb.sv
`timescale 1ns/10ps
module two_bit_io_port_tb;
    localparam logic [15:0] A_DAT = io_port_pkg::DATA_OFFSET;
    localparam logic [15:0] A_DIR = io_port_pkg::DIR_OFFSET;
    localparam logic [15:0] A_MOD = io_port_pkg::MODE_OFFSET;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [1:0]  pin_in, pin_out, pin_oe_n, dir, dat;
    int          errors, samples_checked;
    io_port_pkg::power_mode_t fl [3] = '{io_port_pkg::MODE_STANDBY, io_port_pkg::MODE_WATCH,
                                        io_port_pkg::MODE_SUBACTIVE};

    two_bit_io_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_pin_in(pin_in), .port_pin_out(pin_out),
        .port_pin_oe_n(pin_oe_n));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] exp_data(input logic [1:0] d, input logic [1:0] v,
                                             input logic [1:0] p);
        return {24'h000000, io_port_pkg::RESERVED_ONES | {6'h00, (d & v) | (~d & p)}};
    endfunction

    task automatic give_verdict();
        $display("counts: %0d mismatches, %0d compares", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_pin(input string nm, input logic [1:0] e, input logic [1:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            errors++;
            give_verdict();
        end
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h00000000;
        pin_in = 2'b10;
        errors = 0;
        samples_checked = 0;
        seed = 32'h00000004;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk_pin("oe_n", 2'b11, pin_oe_n);
        chk_pin("out", 2'b00, pin_out);
        repeat (2) @(posedge pclk);
        apb(1'b0, A_DAT, 32'h0);
        chk_reg("data", 32'h000000FE, rd);
        apb(1'b0, A_DIR, 32'h0);
        chk_reg("dir", 32'h000000FF, rd);
        $display("test reset done");
        for (int i = 0; i < 40; i++) begin
            void'(rnd());
            dir = (i < 4) ? i[1:0] : seed[1:0];
            dat = seed[3:2];
            pin_in <= seed[5:4];
            apb(1'b1, A_DIR, {seed[31:2], dir});
            apb(1'b1, A_DAT, {seed[29:0], dat});
            repeat (3) @(posedge pclk);
            chk_pin("oe_n", ~dir, pin_oe_n);
            chk_pin("out", dat & dir, pin_out & dir);
            apb(1'b0, A_DAT, 32'h0);
            chk_reg("data", exp_data(dir, dat, pin_in), rd);
            apb(1'b0, A_DIR, 32'h0);
            chk_reg("dir", 32'h000000FF, rd);
        end
        $display("test random done");
        apb(1'b1, 16'hFFDB, 32'hFFFFFFFF);
        apb(1'b0, 16'hFFDB, 32'h0);
        chk_reg("unmapped", 32'h0, rd);
        apb(1'b1, A_DIR, 32'h3);
        dir = 2'b11;
        apb(1'b1, A_MOD, {29'h0, io_port_pkg::MODE_SLEEP});
        apb(1'b1, A_DAT, {30'h0, ~dat});
        repeat (3) @(posedge pclk);
        chk_pin("sleep out", dat, pin_out);
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, A_MOD, {29'h0, fl[k]});
            repeat (3) @(posedge pclk);
            chk_pin("float oe_n", 2'b11, pin_oe_n);
        end
        apb(1'b1, A_MOD, {29'h0, io_port_pkg::MODE_ACTIVE});
        repeat (3) @(posedge pclk);
        chk_pin("active oe_n", 2'b00, pin_oe_n);
        chk_pin("active out", ~dat, pin_out);
        $display("test modes done");
        give_verdict();
    end
endmodule
